// ---- common/sctg_map.svh ----
`ifndef SCTG_MAP_SVH
`define SCTG_MAP_SVH

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define SCTG_CTRL_SEL_BIT 0
`define SCTG_FMT_PHASE_BIT 16
`define SCTG_FMT_POL_BIT 17
`define SCTG_FMT_PS_LSB 8
`define SCTG_FMT_PS_MSB 15
`define SCTG_DLY_C2T_LSB 24
`define SCTG_DLY_C2T_MSB 31
`define SCTG_DLY_T2C_LSB 16
`define SCTG_DLY_T2C_MSB 23

// ------------------------------------------------------------
// timing counts, in bus clock cycles
// ------------------------------------------------------------
`define SCTG_PS0_PERIOD 10'h002
`define SCTG_C2T_BASE 10'h002
`define SCTG_C2T_HOLD 10'h003
`define SCTG_T2C_BASE 10'h001

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define SCTG_RST_WORD 16'h0000

`endif

// ---- common/sctg_pkg.sv ----
package sctg_pkg;
    typedef enum logic [1:0] {
        SCTG_IDLE = 2'b00,
        SCTG_SETUP = 2'b01,
        SCTG_XFER = 2'b10,
        SCTG_HOLD = 2'b11
    } sctg_state_t;
endpackage : sctg_pkg

// ---- design/sctg_spi_controller.sv ----
// Operation
// - controller-select bit 0 set: drive serial clock and data, sample incoming data.
// - format bit 16 selects clock phase 0 or phase 1.
// - format bit 17 selects clock polarity, hence the active edge.
// - clock period is prescale_value + 1 cycles, or 2 cycles for value 0.
// - serial clock spends half the period, rounded down, after the leading edge and the rest after the trailing one.
// - cs to first edge: delay + 2, or + 3 with hold; phase 1 adds half period.
// - after last edge, chip select stays active clock_to_cs_delay + 1 cycles.
// - both delays come from fields of the delay register.
`include "sctg_map.svh"

module sctg_spi_controller #(
    parameter int DATA_W = 16
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [31:0] serial_global_control,
    input wire logic [31:0] serial_format_reg,
    input wire logic [31:0] serial_delay_reg,
    input wire logic cs_hold_keep,
    input wire logic start,
    input wire logic [DATA_W-1:0] tx_data,
    input wire logic controller_in_line,
    output logic serial_clock_pin,
    output logic serial_clock_oe,
    output logic controller_out_line,
    output logic controller_out_oe,
    output logic cs_active_n,
    output logic busy,
    output logic done,
    output logic [DATA_W-1:0] rx_data
);
    localparam int EW = $clog2(2 * DATA_W);
    localparam logic [EW-1:0] LAST_EDGE = EW'(2 * DATA_W - 1);

    // edge counter and shift registers are sized for 2..32 bits only
    if (DATA_W < 2 || DATA_W > 32) begin : gen_bad_width
        $error("sctg_spi_controller: DATA_W must lie in 2..32");
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [9:0] period_of(input logic [7:0] ps);
        period_of = (ps == 8'h00) ? `SCTG_PS0_PERIOD : {2'b00, ps} + 10'h001;
    endfunction : period_of

    // half after the leading edge gets the floor, the other half the rest, so odd periods stay within a cycle
    function automatic logic [9:0] half_of(input logic [9:0] per);
        half_of = {1'b0, per[9:1]};
    endfunction : half_of

    // ------------------------------------------------------------
    // configuration decode
    // ------------------------------------------------------------
    logic ctrl_mode;
    logic cfg_phase;
    logic cfg_pol;
    logic [7:0] cfg_ps;
    logic [7:0] cfg_c2t;
    logic [7:0] cfg_t2c;
    assign ctrl_mode = serial_global_control[`SCTG_CTRL_SEL_BIT];
    assign cfg_phase = serial_format_reg[`SCTG_FMT_PHASE_BIT];
    assign cfg_pol = serial_format_reg[`SCTG_FMT_POL_BIT];
    assign cfg_ps = serial_format_reg[`SCTG_FMT_PS_MSB:`SCTG_FMT_PS_LSB];
    assign cfg_c2t = serial_delay_reg[`SCTG_DLY_C2T_MSB:`SCTG_DLY_C2T_LSB];
    assign cfg_t2c = serial_delay_reg[`SCTG_DLY_T2C_MSB:`SCTG_DLY_T2C_LSB];

    // ------------------------------------------------------------
    // incoming line synchroniser
    // ------------------------------------------------------------
    // three stages and a filter register add latency; at the fastest prescale the sampled bit
    // lags the line by four cycles, a known limitation
    logic din_s1_r;
    logic din_s2_r;
    logic din_s3_r;
    logic din_r;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            din_s1_r <= 1'b0;
            din_s2_r <= 1'b0;
            din_s3_r <= 1'b0;
            din_r <= 1'b0;
        end else begin
            din_s1_r <= controller_in_line;
            din_s2_r <= din_s1_r;
            din_s3_r <= din_s2_r;
            if (din_s2_r == din_s3_r) begin
                din_r <= din_s3_r;
            end
        end
    end

    // ------------------------------------------------------------
    // sequencer: setup delay, clock edges, hold delay
    // ------------------------------------------------------------
    sctg_pkg::sctg_state_t state_r;
    logic [9:0] cnt_r;
    logic [9:0] per_r;
    logic [EW-1:0] edge_r;
    logic phase_r;
    logic edge_now;
    logic lead_edge;
    logic last_edge;
    logic [9:0] setup_nxt;

    assign edge_now = (state_r == sctg_pkg::SCTG_SETUP || state_r == sctg_pkg::SCTG_XFER)
        && cnt_r == 10'h000;
    assign lead_edge = edge_now && !edge_r[0];
    assign last_edge = edge_now && edge_r == LAST_EDGE;

    always_comb begin
        setup_nxt = {2'b00, cfg_c2t} + (cs_hold_keep ? `SCTG_C2T_HOLD : `SCTG_C2T_BASE);
        if (cfg_phase) begin
            setup_nxt = setup_nxt + half_of(period_of(cfg_ps));
        end
        setup_nxt = setup_nxt - 10'h001;
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= sctg_pkg::SCTG_IDLE;
            cnt_r <= 10'h000;
            per_r <= `SCTG_PS0_PERIOD;
            edge_r <= '0;
            phase_r <= 1'b0;
            cs_active_n <= 1'b1;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state_r)
                sctg_pkg::SCTG_IDLE: begin
                    if (start && ctrl_mode) begin
                        state_r <= sctg_pkg::SCTG_SETUP;
                        cnt_r <= setup_nxt;
                        per_r <= period_of(cfg_ps);
                        phase_r <= cfg_phase;
                        edge_r <= '0;
                        cs_active_n <= 1'b0;
                        busy <= 1'b1;
                    end
                end
                sctg_pkg::SCTG_SETUP, sctg_pkg::SCTG_XFER: begin
                    if (!edge_now) begin
                        cnt_r <= cnt_r - 10'h001;
                    end else if (last_edge) begin
                        state_r <= sctg_pkg::SCTG_HOLD;
                        cnt_r <= {2'b00, cfg_t2c} + `SCTG_T2C_BASE - 10'h001;
                    end else begin
                        state_r <= sctg_pkg::SCTG_XFER;
                        edge_r <= edge_r + EW'(1);
                        // leading edge starts the first half, trailing the second
                        cnt_r <= (edge_r[0] ? per_r - half_of(per_r) : half_of(per_r))
                            - 10'h001;
                    end
                end
                sctg_pkg::SCTG_HOLD: begin
                    if (cnt_r == 10'h000) begin
                        state_r <= sctg_pkg::SCTG_IDLE;
                        cs_active_n <= 1'b1;
                        busy <= 1'b0;
                        done <= 1'b1;
                    end else begin
                        cnt_r <= cnt_r - 10'h001;
                    end
                end
                default: begin
                    state_r <= sctg_pkg::SCTG_IDLE;
                    cs_active_n <= 1'b1;
                    busy <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // serial clock and pin enables
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            serial_clock_pin <= 1'b0;
            serial_clock_oe <= 1'b0;
            controller_out_oe <= 1'b0;
        end else begin
            serial_clock_oe <= ctrl_mode;
            controller_out_oe <= ctrl_mode;
            if (state_r == sctg_pkg::SCTG_IDLE) begin
                serial_clock_pin <= cfg_pol;
            end else if (edge_now) begin
                serial_clock_pin <= ~serial_clock_pin;
            end
        end
    end

    // ------------------------------------------------------------
    // shift data path
    // ------------------------------------------------------------
    logic [DATA_W-1:0] tx_sh_r;
    logic [DATA_W-1:0] rx_sh_r;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tx_sh_r <= '0;
            rx_sh_r <= '0;
            rx_data <= '0;
            controller_out_line <= 1'b0;
        end else if (state_r == sctg_pkg::SCTG_IDLE) begin
            if (start && ctrl_mode) begin
                if (!cfg_phase) begin
                    controller_out_line <= tx_data[DATA_W-1];
                    tx_sh_r <= {tx_data[DATA_W-2:0], 1'b0};
                end else begin
                    tx_sh_r <= tx_data;
                end
            end
        end else if (edge_now) begin
            // phase 0 drives on trailing edges except the last, phase 1 on leading ones
            if ((lead_edge == phase_r) && !(last_edge && !phase_r)) begin
                controller_out_line <= tx_sh_r[DATA_W-1];
                tx_sh_r <= {tx_sh_r[DATA_W-2:0], 1'b0};
            end
            if (lead_edge != phase_r) begin
                rx_sh_r <= {rx_sh_r[DATA_W-2:0], din_r};
            end
            if (last_edge) begin
                rx_data <= phase_r ? {rx_sh_r[DATA_W-2:0], din_r} : rx_sh_r;
            end
        end
    end
endmodule : sctg_spi_controller

// ---- testbench/sctg_spi_props.sv ----
module sctg_spi_props #(parameter int DATA_W = 16) (
    input wire logic sys_clk, input wire logic rstn,
    input wire logic [31:0] serial_global_control, input wire logic [31:0] serial_format_reg,
    input wire logic [31:0] serial_delay_reg, input wire logic cs_hold_keep,
    input wire logic start, input wire logic [DATA_W-1:0] tx_data,
    input wire logic serial_clock_pin, input wire logic controller_out_line,
    input wire logic cs_active_n, input wire logic busy, input wire logic done
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] cnt_r;
    logic pin_q;
    logic [6:0] ecnt_r;
    logic [9:0] p;
    logic [9:0] h;
    wire pol = serial_format_reg[17];
    wire ph = serial_format_reg[16];
    assign p = (serial_format_reg[15:8] == 8'h00) ? 10'h002 : serial_format_reg[15:8] + 10'h001;
    assign h = p >> 1;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // cycles since cs fall or the last clock edge
    // explicit previous sample keeps the helper free of clock inference
    always_ff @(posedge sys_clk) begin
        pin_q <= serial_clock_pin;
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= 10'h000;
            ecnt_r <= 7'h00;
        end else if (cs_active_n) begin
            cnt_r <= 10'h000;
            ecnt_r <= 7'h00;
        end else if (serial_clock_pin != pin_q) begin
            cnt_r <= 10'h001;
            ecnt_r <= ecnt_r + 7'h01;
        end else begin
            cnt_r <= cnt_r + 10'h001;
        end
    end
    busy_cs_a: assert property (busy != cs_active_n) else $error("busy and cs disagree");
    take_start_a: assert property (start && !busy && serial_global_control[0] |=> !cs_active_n)
        else $error("start not taken");
    refuse_start_a: assert property (!serial_global_control[0] && cs_active_n |=> cs_active_n)
        else $error("start taken in non-controller mode");
    done_rel_a: assert property (done == $rose(cs_active_n)) else $error("done misplaced");
    setup_a: assert property ($changed(serial_clock_pin) && !cs_active_n && ecnt_r == 0
        |-> cnt_r == serial_delay_reg[31:24] + 2 + cs_hold_keep + (ph ? h : 0))
        else $error("cs to clock delay wrong");
    half_a: assert property ($changed(serial_clock_pin) && !cs_active_n && ecnt_r != 0
        |-> cnt_r == ((serial_clock_pin == pol) ? h : p - h)) else $error("half period wrong");
    hold_a: assert property ($rose(cs_active_n)
        |-> cnt_r == serial_delay_reg[23:16] + 1 && ecnt_r == 2 * DATA_W)
        else $error("clock to cs delay or edge count wrong");
    first_bit_a: assert property ($fell(cs_active_n) && !ph
        |-> controller_out_line == tx_data[DATA_W-1]) else $error("first bit late");
    out_edge_a: assert property ($changed(controller_out_line) && !cs_active_n
        && !$fell(cs_active_n) |-> $changed(serial_clock_pin) && ((serial_clock_pin == pol) != ph))
        else $error("data moved on wrong edge");
    idle_clk_a: assert property (!busy && $stable(pol) && $past(rstn)
        |-> serial_clock_pin == pol) else $error("idle clock level wrong");
endmodule : sctg_spi_props
bind sctg_spi_controller sctg_spi_props #(.DATA_W(DATA_W)) props_u (.sys_clk, .rstn,
    .serial_global_control, .serial_format_reg, .serial_delay_reg, .cs_hold_keep, .start,
    .tx_data, .serial_clock_pin, .controller_out_line, .cs_active_n, .busy, .done);

// ---- testbench/sctg_periph_model.sv ----
module sctg_periph_model (
    input wire logic sys_clk,
    input wire logic cs_active_n,
    input wire logic serial_clock_pin,
    input wire logic controller_out_line,
    input wire logic pol,
    input wire logic ph,
    input wire logic [15:0] word,
    output logic controller_in_line,
    output logic [15:0] got
);
    timeunit 1ns;
    timeprecision 1ns;
    logic prev = 1'b0;
    logic first = 1'b1;
    logic [15:0] sh;
    wire edg = prev != serial_clock_pin;
    wire lead = edg && serial_clock_pin != pol;
    initial controller_in_line = 1'b0;
    always @(posedge sys_clk) begin
        prev <= serial_clock_pin;
        if (cs_active_n) begin
            sh <= word;
            first <= 1'b1;
            // released line toggles so no stale bit can pass for data
            controller_in_line <= ~controller_in_line;
        end else begin
            first <= 1'b0;
            if (edg && lead != ph) got <= {got[14:0], controller_out_line};
            if ((first && !ph) || (!first && edg && lead == ph)) begin
                controller_in_line <= sh[15];
                sh <= sh << 1;
            end
        end
    end
endmodule : sctg_periph_model

// ---- testbench/testbench.sv ----
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, rstn, cs_hold_keep, start, controller_in_line, serial_clock_pin;
    logic serial_clock_oe, controller_out_line, controller_out_oe, cs_active_n, busy, done;
    logic [31:0] serial_global_control, serial_format_reg, serial_delay_reg;
    logic [15:0] tx_data, rx_data, word, got;
    int error_cnt = 0;
    int tests_run = 0;
    int seed = 32'h0000_541f;
    sctg_spi_controller dut_u (.sys_clk, .rstn, .serial_global_control, .serial_format_reg,
        .serial_delay_reg, .cs_hold_keep, .start, .tx_data, .controller_in_line,
        .serial_clock_pin, .serial_clock_oe, .controller_out_line, .controller_out_oe,
        .cs_active_n, .busy, .done, .rx_data);
    sctg_periph_model periph_u (.sys_clk, .cs_active_n, .serial_clock_pin, .controller_out_line,
        .pol(serial_format_reg[17]), .ph(serial_format_reg[16]), .word, .controller_in_line,
        .got);
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic test_done;
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : test_done
    task automatic check(input logic [15:0] a, input logic [15:0] e);
        tests_run++;
        if (a !== e) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, a, e);
        end
    endtask : check
    function automatic int xlen(int s, int c, int t, int hd, int ph);
        int p;
        p = (s == 0) ? 2 : s + 1;
        return c + 2 + hd + ph * (p / 2) + 16 * p - (p - p / 2) + t + 1;
    endfunction : xlen
    task automatic xfer(input int s, input int c, input int t, input logic hd, pl, ph);
        int n;
        @(posedge sys_clk);
        #1;
        serial_format_reg = {14'h0000, pl, ph, s[7:0], 8'h00};
        serial_delay_reg = {c[7:0], t[7:0], 16'h0000};
        cs_hold_keep = hd;
        tx_data = 16'($random(seed));
        word = 16'($random(seed));
        // config settles one cycle ahead so idle level is not mistaken for an edge
        @(posedge sys_clk);
        #1;
        start = 1'b1;
        @(posedge sys_clk);
        #1;
        start = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 9000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check(16'(n), 16'(xlen(s, c, t, hd, ph)));
        // receive path lags the pin, so data is judged only at slow clocks
        if (s > 10 && c > 3) begin
            check(rx_data, word);
            check(got, tx_data);
        end
    endtask : xfer
    initial begin
        rstn = 1'b0;
        start = 1'b0;
        cs_hold_keep = 1'b0;
        serial_global_control = 32'h0000_0000;
        serial_format_reg = 32'h0000_0b00;
        serial_delay_reg = 32'h0000_0000;
        tx_data = 16'h0000;
        word = 16'h0000;
        repeat (5) @(posedge sys_clk);
        #1;
        rstn = 1'b1;
        start = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        check({15'h0000, busy}, 16'h0000);
        check({15'h0000, serial_clock_oe}, 16'h0000);
        start = 1'b0;
        serial_global_control = 32'h0000_0001;
        @(posedge sys_clk);
        #1;
        check({15'h0000, serial_clock_oe & controller_out_oe}, 16'h0001);
        xfer(2, 0, 0, 1'b0, 1'b0, 1'b0);
        xfer(255, 4, 255, 1'b1, 1'b1, 1'b1);
        for (int i = 0; i < 12; i++) begin
            xfer(11 + {$random(seed)} % 16, 4 + {$random(seed)} % 12, {$random(seed)} % 8,
                1'($random(seed)), i[0], i[1]);
        end
        test_done();
    end
    initial begin
        #1_000_000;
        error_cnt++;
        test_done();
    end
endmodule : testbench
